// file: core/seg_latch_pkg.sv
package seg_latch_pkg;

  // ==========================================================
  // device variants
  typedef enum logic [1:0] {
    VAR_SEG40,
    VAR_SEG64,
    VAR_SEG32
  } variant_t;

  // ==========================================================
  // word framing
  localparam int WORD_LEN_SHORT = 22;
  localparam int WORD_LEN_LONG = 34;
  localparam int SEG_COUNT_40 = 40;
  localparam int SEG_COUNT_64 = 64;
  localparam int SEG_COUNT_32 = 32;
  localparam int PINS_SHORT = 20;
  localparam int PINS_LONG = 32;
  localparam int SEG_PINS_MAX = 32;
  localparam int WORD_MAX = 34;
  localparam int CNT_W = 6;
  localparam logic [CNT_W-1:0] CNT_RESET = 6'h00;
  localparam logic [CNT_W-1:0] CNT_SAT = 6'h3f;

  // ==========================================================
  // backplane timing (internal oscillator model)
  localparam int CLK_SYS_HZ = 40_000_000;
  localparam int BP_HALF_PERIOD_US = 4000;
  localparam int BP_HALF_CYCLES =
    (CLK_SYS_HZ / 1_000_000) * BP_HALF_PERIOD_US;
  localparam int DIV_W = 20;

  // ==========================================================
  // receiver states
  typedef enum logic [0:0] {
    RX_WAIT,
    RX_SHIFT
  } rx_state_t;

  // two-flop synchroniser stages for the pins
  typedef struct packed {
    logic burst_clock;
    logic data;
    logic enable;
    logic osc_gnd;
    logic bp_ext;
  } pin_sample_t;

  typedef struct packed {
    pin_sample_t meta;
    pin_sample_t sync;
    pin_sample_t prev;
    rx_state_t rx;
    logic [WORD_MAX-1:0] shift;
    logic [CNT_W-1:0] count;
    logic framing_err;
    logic [SEG_PINS_MAX-1:0] bank_a;
    logic [SEG_PINS_MAX-1:0] bank_b;
    logic [DIV_W-1:0] div;
    logic phase;
    logic [SEG_PINS_MAX-1:0] segment_out;
    logic bp_first;
    logic bp_second;
    logic bp_single;
    logic bp_drive;
  } state_t;

  localparam state_t STATE_RESET = '0;

endpackage : seg_latch_pkg

// file: core/lcd_serial_latch_loader.sv

`timescale 1ns/1ps
`default_nettype none

module lcd_serial_latch_loader
  import seg_latch_pkg::*;
#(
  parameter variant_t VARIANT = VAR_SEG40,
  parameter int BP_HALF = BP_HALF_CYCLES
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic burst_clock_in,
  input wire logic data_in,
  input wire logic data_line_enable,
  input wire logic osc_grounded,
  input wire logic backplane_first_in,
  output logic backplane_first_out,
  output logic backplane_first_oe,
  input wire logic backplane_second_in,
  output logic backplane_second_out,
  output logic backplane_second_oe,
  input wire logic backplane_single_in,
  output logic backplane_single_out,
  output logic backplane_single_oe,
  output logic [SEG_PINS_MAX-1:0] segment_out
);

  // ==========================================================
  // variant constants
  localparam bit SHORT_WORD = (VARIANT == VAR_SEG40);
  localparam bit ONE_BP = (VARIANT == VAR_SEG32);
  localparam int WORD_LEN = SHORT_WORD ? WORD_LEN_SHORT : WORD_LEN_LONG;
  localparam int SEG_PINS = SHORT_WORD ? PINS_SHORT : PINS_LONG;
  localparam int SEL_BIT = WORD_LEN - 1;
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(WORD_LEN);
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BP_HALF - 1);

  state_t r;
  state_t next_r;

  logic burst_rise;
  logic burst_high;
  logic load_cond;
  logic word_ok;
  logic bp_level;
  logic [SEG_PINS_MAX-1:0] shown;
  logic [SEG_PINS_MAX-1:0] word_segs;

  // ==========================================================
  // next-state logic
  always_comb begin
    next_r = r;

    // pins pass two flops before anything reads them
    next_r.meta.burst_clock = burst_clock_in;
    next_r.meta.data = data_in;
    next_r.meta.enable = data_line_enable;
    next_r.meta.osc_gnd = osc_grounded;
    next_r.meta.bp_ext = ONE_BP ? backplane_single_in : backplane_first_in;
    next_r.sync = r.meta;
    next_r.prev = r.sync;

    burst_rise = r.sync.burst_clock && !r.prev.burst_clock;
    burst_high = r.sync.burst_clock && r.prev.burst_clock;
    load_cond = burst_rise && !r.sync.enable;

    // segment field sits in bits 1..SEG_PINS, bit 0 is the leading zero
    word_segs = '0;
    for (int i = 0; i < SEG_PINS; i++) begin
      word_segs[i] = r.shift[i + 1];
    end

    word_ok = !r.framing_err && (r.count == CNT_FULL);

    unique case (r.rx)
      RX_WAIT: begin
        // a rising enable always starts clean; no recovery step needed
        if (r.sync.enable && !r.prev.enable) begin
          next_r.rx = RX_SHIFT;
          next_r.count = CNT_RESET;
          next_r.framing_err = 1'b0;
          next_r.shift = '0;
        end
      end
      RX_SHIFT: begin
        if (burst_rise && r.sync.enable) begin
          if (r.count < CNT_W'(WORD_MAX)) begin
            next_r.shift[r.count] = r.sync.data;
          end
          if (r.count == CNT_RESET && r.sync.data) begin
            next_r.framing_err = 1'b1;
          end
          if (r.count != CNT_SAT) begin
            next_r.count = r.count + 6'h01;
          end
        end
        // data and enable must stay put while the burst clock is high
        if (burst_high && ((r.sync.data != r.prev.data) ||
                         (r.sync.enable != r.prev.enable))) begin
          next_r.framing_err = 1'b1;
        end
        if (load_cond) begin
          // the load pulse is pulse WORD_LEN+1 of the burst
          if (word_ok) begin
            if (ONE_BP) begin
              if (r.shift[SEL_BIT]) begin
                next_r.bank_a = word_segs;
              end
            end else if (r.shift[SEL_BIT]) begin
              next_r.bank_a = word_segs;
            end else begin
              next_r.bank_b = word_segs;
            end
          end
          next_r.rx = RX_WAIT;
        end else if (r.sync.enable && !r.prev.enable) begin
          // enable re-raised without a load: restart the word
          next_r.count = CNT_RESET;
          next_r.framing_err = 1'b0;
          next_r.shift = '0;
        end
      end
    endcase

    // internal oscillator model: fixed half-period divider
    if (r.div == DIV_LAST) begin
      next_r.div = '0;
      next_r.phase = !r.phase;
    end else begin
      next_r.div = r.div + 20'h00001;
    end

    // slave mode follows the master's backplane level instead
    next_r.bp_drive = !r.sync.osc_gnd;
    bp_level = r.sync.osc_gnd ? r.sync.bp_ext : r.phase;

    next_r.bp_first = bp_level;
    next_r.bp_second = !bp_level;
    next_r.bp_single = bp_level;

    // an on segment is driven out of phase with its backplane
    if (ONE_BP) begin
      shown = r.bank_a;
    end else begin
      shown = bp_level ? r.bank_a : r.bank_b;
    end
    for (int i = 0; i < SEG_PINS_MAX; i++) begin
      if (i < SEG_PINS) begin
        next_r.segment_out[i] = shown[i] ? !bp_level : bp_level;
      end else begin
        next_r.segment_out[i] = 1'b0;
      end
    end
  end

  // ==========================================================
  // state register; reset is the power-on clear
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      r <= STATE_RESET;
    end else begin
      r <= next_r;
    end
  end

  // ==========================================================
  // pins
  // the single-backplane part only ever drives its single backplane,
  // so it cannot master the two-backplane parts
  assign backplane_single_out = ONE_BP ? r.bp_single : 1'b0;
  assign backplane_single_oe = ONE_BP && r.bp_drive;
  assign backplane_first_out = ONE_BP ? 1'b0 : r.bp_first;
  assign backplane_first_oe = !ONE_BP && r.bp_drive;
  assign backplane_second_out = ONE_BP ? 1'b0 : r.bp_second;
  assign backplane_second_oe = !ONE_BP && r.bp_drive;
  assign segment_out = r.segment_out;

endmodule : lcd_serial_latch_loader

`default_nettype wire

// file: verification/seg_latch_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// port checker
module seg_latch_chk
  import seg_latch_pkg::*;
#(
  parameter variant_t VARIANT = VAR_SEG40
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic data_line_enable,
  input wire logic osc_grounded,
  input wire logic backplane_first_out,
  input wire logic backplane_first_oe,
  input wire logic backplane_second_out,
  input wire logic backplane_second_oe,
  input wire logic backplane_single_out,
  input wire logic backplane_single_oe,
  input wire logic [SEG_PINS_MAX-1:0] segment_out
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  AST_RESET_SEG: assert property (disable iff (1'b0) reset |=>
    segment_out == '0 && !backplane_first_oe) else $error("seg not cleared");
  AST_RESET_BP: assert property (disable iff (1'b0) reset |=>
    !backplane_first_out) else $error("backplane not cleared");
  AST_BP_ANTI: assert property (backplane_first_oe |->
    backplane_second_out != backplane_first_out) else $error("bp in phase");
  AST_OE_PAIR: assert property (backplane_first_oe == backplane_second_oe)
    else $error("bp enables differ");
  AST_SLAVE_HIZ: assert property (osc_grounded [*5] |->
    !backplane_first_oe) else $error("slave still drives");
  AST_NO_SINGLE: assert property (VARIANT != VAR_SEG32 |->
    !backplane_single_oe && !backplane_single_out) else $error("single bp");
  AST_HIGH_PINS: assert property (VARIANT == VAR_SEG40 |->
    segment_out[31:20] == '0) else $error("unused pins active");
  AST_BP_HALF: assert property (backplane_first_oe &&
    $changed(backplane_first_out) |=> $stable(backplane_first_out) [*8])
    else $error("backplane too fast");
  // shifting must never reach the latches before the load pulse
  AST_SEG_STILL: assert property ((data_line_enable &&
    $stable(backplane_first_out)) [*8] |-> $stable(segment_out))
    else $error("segments moved while shifting");
  cover property (backplane_first_oe && $rose(backplane_first_out));
  cover property ($changed(segment_out) && !data_line_enable);
  cover property (osc_grounded && !backplane_first_oe);
endmodule : seg_latch_chk
bind lcd_serial_latch_loader seg_latch_chk #(.VARIANT(VARIANT)) i_chk (
  .clk_sys(clk_sys), .reset(reset), .data_line_enable(data_line_enable),
  .osc_grounded(osc_grounded), .backplane_first_out(backplane_first_out),
  .backplane_first_oe(backplane_first_oe),
  .backplane_second_out(backplane_second_out),
  .backplane_second_oe(backplane_second_oe),
  .backplane_single_out(backplane_single_out),
  .backplane_single_oe(backplane_single_oe), .segment_out(segment_out));
`default_nettype wire

// file: verification/host_link_model.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// host side of the three-wire link, 200 ns burst clock
module host_link_model (
  input wire logic clk_sys,
  output logic burst_clock_in,
  output logic data_in,
  output logic data_line_enable
);
  initial begin
    burst_clock_in = 1'b0;
    data_in = 1'b1;
    data_line_enable = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys);
  endtask : tick
  // glitch flips data while the clock is high on bit 3
  task automatic send(input logic [33:0] w, input int n, input bit glitch);
    tick(1);
    data_line_enable <= 1'b1;
    for (int k = 0; k < n; k++) begin
      data_in <= w[k];
      tick(4);
      burst_clock_in <= 1'b1;
      tick(2);
      if (glitch && k == 3) data_in <= ~w[k];
      tick(2);
      burst_clock_in <= 1'b0;
    end
    tick(2);
    data_line_enable <= 1'b0;
    tick(2);
    burst_clock_in <= 1'b1;
    tick(4);
    burst_clock_in <= 1'b0;
    data_in <= ~data_in;
    tick(4);
  endtask : send
endmodule : host_link_model
`default_nettype wire

// file: verification/lcd_serial_latch_loader_tb.sv
`timescale 1ns/1ps
`default_nettype none
// ========================================
// bench, short-word variant
module lcd_serial_latch_loader_tb;
  import seg_latch_pkg::*;
  logic clk_sys, reset, osc_grounded, back_in, burst, dat, en;
  logic back_a, back_a_oe, back_b, back_b_oe, back_s, back_s_oe;
  logic [31:0] seg;
  logic [19:0] ea, eb;
  int err_total, tests_run;
  host_link_model i_host (.clk_sys(clk_sys), .burst_clock_in(burst),
    .data_in(dat), .data_line_enable(en));
  lcd_serial_latch_loader #(.VARIANT(VAR_SEG40), .BP_HALF(16)) i_dut (
    .clk_sys(clk_sys), .reset(reset), .burst_clock_in(burst), .data_in(dat),
    .data_line_enable(en), .osc_grounded(osc_grounded),
    .backplane_first_in(back_in), .backplane_first_out(back_a),
    .backplane_first_oe(back_a_oe), .backplane_second_in(1'b0),
    .backplane_second_out(back_b), .backplane_second_oe(back_b_oe),
    .backplane_single_in(1'b0), .backplane_single_out(back_s),
    .backplane_single_oe(back_s_oe), .segment_out(seg));
  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task automatic check(input string nm, input logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  // an on segment is driven opposite to the backplane level on show
  function automatic logic [31:0] drv(input logic [19:0] b, logic lvl);
    return {12'h000, b ^ {20{lvl}}};
  endfunction : drv
  function automatic logic [33:0] wd(input logic [19:0] p, logic a);
    return {12'h000, a, p, 1'b0};
  endfunction : wd
  task automatic wait_bp(input logic v);
    int n;
    n = 0;
    while (back_a === v && n < 80) begin @(posedge clk_sys); n++; end
    while (back_a !== v && n < 160) begin @(posedge clk_sys); n++; end
    if (n >= 160) begin err_total++; conclude(); end
    repeat (4) @(posedge clk_sys);
  endtask : wait_bp
  task automatic show();
    wait_bp(1'b1);
    check("bank_a", seg, drv(ea, 1'b1));
    check("bp_pair", {30'h0, back_a, back_b}, 32'h2);
    wait_bp(1'b0);
    check("bank_b", seg, drv(eb, 1'b0));
    check("single_off", {30'h0, back_s, back_s_oe}, 32'h0);
  endtask : show
  task automatic t_banks();
    ea = 20'ha5c3f;
    eb = 20'h1e2d4;
    i_host.send(wd(ea, 1'b1), 22, 1'b0);
    i_host.send(wd(eb, 1'b0), 22, 1'b0);
    check("master_oe", {30'h0, back_a_oe, back_b_oe}, 32'h3);
    show();
  endtask : t_banks
  task automatic t_refuse();
    i_host.send(wd(20'h0f0f0, 1'b1) | 34'h1, 22, 1'b0);
    i_host.send(wd(20'h33333, 1'b0), 21, 1'b0);
    i_host.send(wd(20'h6c6c6, 1'b1), 23, 1'b0);
    i_host.send(wd(20'h9b9b9, 1'b0), 22, 1'b1);
    show();
    ea = 20'h5a5a5;
    i_host.send(wd(ea, 1'b1), 22, 1'b0);
    show();
  endtask : t_refuse
  task automatic t_slave();
    @(posedge clk_sys);
    osc_grounded <= 1'b1;
    back_in <= 1'b1;
    repeat (10) @(posedge clk_sys);
    check("slave_oe", {31'h0, back_a_oe}, 32'h0);
    check("slave_a", seg, drv(ea, 1'b1));
    back_in <= 1'b0;
    repeat (10) @(posedge clk_sys);
    check("slave_b", seg, drv(eb, 1'b0));
  endtask : t_slave
  initial begin
    reset = 1'b1;
    osc_grounded = 1'b0;
    back_in = 1'b0;
    err_total = 0;
    tests_run = 0;
    repeat (6) @(posedge clk_sys);
    reset <= 1'b0;
    t_banks();
    t_refuse();
    t_slave();
    conclude();
  end
endmodule : lcd_serial_latch_loader_tb
`default_nettype wire
